// ---- burst_addr_pkg.sv ----
// Purpose : Shared widths, types and reset values for the burst address logic
// Assumes : One port clock domain, host on the same clock
// Notes   : In-bank field sized so its top address is FFFh
package burst_addr_pkg;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int BANK_W    = 6;
  localparam int IN_BANK_W = 12;
  localparam int ADDR_W    = BANK_W + IN_BANK_W;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int PORTS     = 2;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;

  typedef logic [ADDR_W-1:0]  addr_t;
  typedef logic [BANK_W-1:0]  bank_t;
  typedef logic [LANES-1:0]   lane_t;
  typedef logic [DATA_W-1:0]  data_t;

  // One port's host-side controls, sampled on the port clock except output enable and latency select, which act combinationally
  typedef struct packed {
    addr_t ext_addr;
    logic  address_strobe_n;
    logic  count_advance_n;
    logic  reload_n;
    logic  write_n;
    logic  chip_select_low_n;
    logic  chip_select_high;
    lane_t byte_lane_enable_n;
    logic  output_enable_n;
    logic  output_latency_select;
  } port_ctrl_t;

endpackage

// ---- port_addr_counter.sv ----
// Purpose : One port's address counter with load, advance, hold and reload
// Assumes : Controls are synchronous to i_core_clk
// Notes   : Reload address is left without reset on purpose
`timescale 1ns/100ps
module port_addr_counter
(
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  // Counter controls
  input  wire burst_addr_pkg::addr_t i_ext_addr,
  input  wire logic                  i_address_strobe_n,
  input  wire logic                  i_count_advance_n,
  input  wire logic                  i_reload_n,
  // State
  output      burst_addr_pkg::addr_t o_addr,
  output      logic                  o_reload_valid
);
  import burst_addr_pkg::*;

  addr_t addr_reg;
  addr_t addr_next;
  addr_t reload_reg;
  addr_t reload_next;
  logic  valid_reg;
  logic  valid_next;

  // ****************************************
  // Next address selection
  // ****************************************
  always_comb
  begin
    addr_next   = addr_reg;
    reload_next = reload_reg;
    valid_next  = valid_reg;
    if (!i_reload_n)
    begin
      addr_next = reload_reg;                         // RL4
    end
    else if (!i_address_strobe_n)
    begin
      addr_next   = i_ext_addr;                       // RL1 RL5
      reload_next = i_ext_addr;                       // RL1 RL7
      valid_next  = 1'b1;
    end
    else if (!i_count_advance_n)
    begin
      // Bank bits sit above in-bank bits, so carry and wrap come free
      addr_next = addr_t'(addr_reg + 1'b1);           // RL2 RL6 RL9 RL10
    end
    else
    begin
      addr_next = addr_reg;                           // RL3
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)   // RL16
  begin
    if (!i_rstn)
    begin
      addr_reg  <= ADDR_RESET;
      valid_reg <= 1'b0;
    end
    else
    begin
      addr_reg  <= addr_next;
      valid_reg <= valid_next;
    end
  end

  // No reset: undefined until the first strobe load
  always_ff @(posedge i_core_clk)
  begin
    reload_reg <= reload_next;                        // RL7
  end

  assign o_addr         = addr_reg;
  assign o_reload_valid = valid_reg;

  // ****************************************
  // Checks
  // ****************************************
  AST_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL1
    (!i_address_strobe_n && i_reload_n) |=> (addr_reg == $past(i_ext_addr)) && (reload_reg == addr_reg))
    else $error("strobe load not taken");
  AST_ADVANCE: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL2
    (i_address_strobe_n && !i_count_advance_n && i_reload_n) |=> addr_reg == addr_t'($past(addr_reg) + 1'b1))
    else $error("counter did not advance by one");
  AST_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL3
    (i_address_strobe_n && i_count_advance_n && i_reload_n) |=> $stable(addr_reg))
    else $error("counter moved while held");
  AST_RELOAD: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL4
    (!i_reload_n && valid_reg) |=> addr_reg == $past(reload_reg))
    else $error("reload did not restore strobed address");
  AST_BANK_CARRY: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL9
    (i_address_strobe_n && !i_count_advance_n && i_reload_n && (&addr_reg[IN_BANK_W-1:0]))
    |=> (addr_reg[IN_BANK_W-1:0] == '0) && (addr_reg[ADDR_W-1:IN_BANK_W] == bank_t'($past(addr_reg[ADDR_W-1:IN_BANK_W]) + 1'b1)))
    else $error("no carry into next bank");
  AST_TOP_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL10
    (i_address_strobe_n && !i_count_advance_n && i_reload_n && (&addr_reg)) |=> addr_reg == '0)
    else $error("top of last bank did not wrap");
  COV_RELOAD: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_address_strobe_n ##1 (!i_count_advance_n && i_address_strobe_n) [*3] ##1 !i_reload_n);
  COV_WRAP: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
    (&addr_reg) && i_address_strobe_n && !i_count_advance_n && i_reload_n);

endmodule // port_addr_counter

// ---- dual_port_burst_address_counter.sv ----
// Purpose : Address counters, access decode and read latency for both ports
// Assumes : Host drives each port's controls on i_core_clk; array answers one cycle after address
// Notes   : Output enable is combinational to the pin enables
// Function
// RL1: Strobe low with reload high loads external address and stores it for reload.
// RL2: Strobe high, advance low, reload high: address steps up by one.
// RL3: Strobe, advance and reload all high: counter value held unchanged.
// RL4: Reload low restores last strobed address regardless of strobe and advance.
// RL5: Strobe load and reload ignore chip selects and byte lane enables.
// RL6: Advance acts even when chip selects or lanes deselect the port.
// RL7: Reload address is undefined until the first strobe load.
// RL8: Host should strobe a known address at start before relying on reload.
// RL9: Counter carries from in-bank FFFh to 0h of the next bank.
// RL10: Top of bank 63 wraps to address zero of bank 0.
// RL11: Pipelined mode delivers read data one cycle later than flow-through.
// RL12: Hosts must keep both counters off the same bank at once.
// RL13: Read, write and lanes decided by select, chip selects, lanes, output enable.
// RL14: Both ports on one bank makes both accesses invalid.
// RL15: Output enable high floats all data outputs at once, without the clock.
// RL16: Each port has its own counter and reload, acting on clock edges only.
`timescale 1ns/100ps
module dual_port_burst_address_counter
(
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rstn,
  // Host controls per port
  input  wire burst_addr_pkg::port_ctrl_t i_port_ctrl   [burst_addr_pkg::PORTS],
  // Array read data per port, for the address presented the cycle before
  input  wire burst_addr_pkg::data_t      i_array_rdata [burst_addr_pkg::PORTS],
  // Array side
  output      burst_addr_pkg::addr_t      o_addr        [burst_addr_pkg::PORTS],
  output      burst_addr_pkg::lane_t      o_array_we    [burst_addr_pkg::PORTS],
  output      logic                       o_reload_valid[burst_addr_pkg::PORTS],
  output      logic                       o_collision,
  // Data pins per port
  output      burst_addr_pkg::data_t      o_dq_out      [burst_addr_pkg::PORTS],
  output      burst_addr_pkg::lane_t      o_dq_oe_n     [burst_addr_pkg::PORTS]
);
  import burst_addr_pkg::*;

  logic  collision_reg;
  logic  collision_next;
  lane_t we_reg    [PORTS];
  lane_t we_next   [PORTS];
  lane_t rd0_reg   [PORTS];
  lane_t rd0_next  [PORTS];
  lane_t rd1_reg   [PORTS];
  lane_t rd1_next  [PORTS];
  logic  bad0_reg  [PORTS];
  logic  bad0_next [PORTS];
  data_t dq0_reg   [PORTS];
  data_t dq0_next  [PORTS];
  data_t dq1_reg   [PORTS];
  data_t dq1_next  [PORTS];

  // ****************************************
  // Bank collision
  // ****************************************
  always_comb
  begin
    // Host is meant to avoid this; flag it rather than arbitrate
    collision_next = (o_addr[0][ADDR_W-1:IN_BANK_W] == o_addr[1][ADDR_W-1:IN_BANK_W]); // RL12 RL14
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      collision_reg <= 1'b0;
    end
    else
    begin
      collision_reg <= collision_next;
    end
  end

  assign o_collision = collision_reg;

  // ****************************************
  // Per-port counter, decode and output path
  // ****************************************
  for (genvar p = 0; p < PORTS; p++)
  begin : g_port
    logic  sel;
    lane_t lanes;
    lane_t out_lanes;

    port_addr_counter u_counter
    (
      .i_core_clk         (i_core_clk),
      .i_rstn             (i_rstn),
      .i_ext_addr         (i_port_ctrl[p].ext_addr),
      .i_address_strobe_n (i_port_ctrl[p].address_strobe_n),
      .i_count_advance_n  (i_port_ctrl[p].count_advance_n),
      .i_reload_n         (i_port_ctrl[p].reload_n),
      .o_addr             (o_addr[p]),
      .o_reload_valid     (o_reload_valid[p])
    ); // RL16

    always_comb
    begin
      sel         = !i_port_ctrl[p].chip_select_low_n && i_port_ctrl[p].chip_select_high; // RL13
      lanes       = sel ? ~i_port_ctrl[p].byte_lane_enable_n : '0;                     // RL13
      we_next[p]  = i_port_ctrl[p].write_n ? '0 : lanes;
      rd0_next[p] = i_port_ctrl[p].write_n ? lanes : '0;
      rd1_next[p] = rd0_reg[p];
      // Writes on a shared bank are dropped; corrupting would be as valid
      bad0_next[p] = collision_next;                                                    // RL14
      dq0_next[p]  = i_array_rdata[p];
      dq1_next[p]  = dq0_reg[p];                                                        // RL11
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
      if (!i_rstn)
      begin
        we_reg[p]   <= '0;
        rd0_reg[p]  <= '0;
        rd1_reg[p]  <= '0;
        bad0_reg[p] <= 1'b0;
        dq0_reg[p]  <= '0;
        dq1_reg[p]  <= '0;
      end
      else
      begin
        we_reg[p]   <= we_next[p];
        rd0_reg[p]  <= rd0_next[p];
        rd1_reg[p]  <= rd1_next[p];
        bad0_reg[p] <= bad0_next[p];
        dq0_reg[p]  <= dq0_next[p];
        dq1_reg[p]  <= dq1_next[p];
      end
    end

    assign o_array_we[p] = collision_reg ? '0 : we_reg[p];                              // RL14
    // Invalid flow-through reads are driven as zero rather than stale data; pipelined reads are not blanked
    assign o_dq_out[p]   = i_port_ctrl[p].output_latency_select ? dq1_reg[p]
                         : (bad0_reg[p] ? '0 : dq0_reg[p]);                             // RL11 RL14
    assign out_lanes     = i_port_ctrl[p].output_latency_select ? rd1_reg[p] : rd0_reg[p];
    assign o_dq_oe_n[p]  = i_port_ctrl[p].output_enable_n ? '1 : ~out_lanes;            // RL15

    // ****************************************
    // Checks
    // ****************************************
    AST_WRITE_LANES: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL13
      (!i_port_ctrl[p].write_n && !i_port_ctrl[p].chip_select_low_n && i_port_ctrl[p].chip_select_high
       && !collision_next) |=> o_array_we[p] == ~$past(i_port_ctrl[p].byte_lane_enable_n))
      else $error("write lanes do not follow lane enables");
    AST_DESELECT: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL6
      (i_port_ctrl[p].chip_select_low_n && i_port_ctrl[p].address_strobe_n && i_port_ctrl[p].reload_n
       && !i_port_ctrl[p].count_advance_n) |=> (o_array_we[p] == '0) && (o_addr[p] == addr_t'($past(o_addr[p]) + 1'b1)))
      else $error("deselected port wrote or failed to advance");
    AST_PIPE_DELAY: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL11
      ##1 1'b1 |-> dq1_reg[p] == $past(dq0_reg[p]))
      else $error("pipelined data not one cycle behind");
    AST_OE_FLOAT: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL15
      i_port_ctrl[p].output_enable_n |-> o_dq_oe_n[p] == '1)
      else $error("data driven with output enable high");
    COV_PIPE_READ: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      i_port_ctrl[p].output_latency_select && !i_port_ctrl[p].output_enable_n && (rd1_reg[p] != '0));
    AST_READ_LANES: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL13
      (i_port_ctrl[p].write_n && !i_port_ctrl[p].chip_select_low_n && i_port_ctrl[p].chip_select_high)
      |=> (i_port_ctrl[p].output_latency_select || i_port_ctrl[p].output_enable_n
           || o_dq_oe_n[p] == $past(i_port_ctrl[p].byte_lane_enable_n)))
      else $error("flow-through pin enables do not follow read lanes");
    AST_PIPE_LANES: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL11
      (i_port_ctrl[p].write_n && !i_port_ctrl[p].chip_select_low_n && i_port_ctrl[p].chip_select_high)
      |-> ##2 (!i_port_ctrl[p].output_latency_select || i_port_ctrl[p].output_enable_n
               || o_dq_oe_n[p] == $past(i_port_ctrl[p].byte_lane_enable_n, 2)))
      else $error("pipelined pin enables not two edges after the read");
    // Flow-through word of a shared-bank cycle is unusable, so it is blanked
    AST_FLOW_INVALID: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL14
      (o_collision && !i_port_ctrl[p].output_latency_select) |-> o_dq_out[p] == '0)
      else $error("flow-through read shown during a bank collision");
    COV_FLOW_READ: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_port_ctrl[p].output_latency_select && !i_port_ctrl[p].output_enable_n && (rd0_reg[p] != '0));
  end

  AST_COLLISION: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL14
    (o_addr[0][ADDR_W-1:IN_BANK_W] == o_addr[1][ADDR_W-1:IN_BANK_W]) |=> o_collision && o_array_we[0] == '0 && o_array_we[1] == '0)
    else $error("same-bank access not blocked");
  AST_COLL_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL14
    (o_addr[0][ADDR_W-1:IN_BANK_W] != o_addr[1][ADDR_W-1:IN_BANK_W]) |=> !o_collision)
    else $error("collision flagged for distinct banks");
  COV_COLLISION: cover property (@(posedge i_core_clk) disable iff (!i_rstn) o_collision);

endmodule // dual_port_burst_address_counter

// ---- burst_array_model.sv ----
// Purpose : Memory array stand-in answering each port's counter address
// Assumes : Array presents data the cycle after the address shows
// Notes   : Data pattern is the address twice, so a stale word is visible
`timescale 1ns/100ps
module burst_array_model
(
  // Clock
  input  wire logic                  i_core_clk,
  // Address in, data out
  input  wire burst_addr_pkg::addr_t i_addr  [burst_addr_pkg::PORTS],
  output      burst_addr_pkg::data_t o_rdata [burst_addr_pkg::PORTS]
);
  import burst_addr_pkg::*;

  // ****************************************
  // Registered read path
  // ****************************************
  always @(posedge i_core_clk)
  begin
    for (int p = 0; p < PORTS; p++) o_rdata[p] <= {i_addr[p], i_addr[p]};
  end
endmodule // burst_array_model

// ---- dual_port_burst_address_counter_tb.sv ----
// Purpose : Directed checks of counter, decode and read latency
// Assumes : Inputs change 2 ns after the rising edge
// Notes   : Results are read 2 ns after the edge that makes them
`timescale 1ns/100ps
module dual_port_burst_address_counter_tb;
  import burst_addr_pkg::*;

  logic       i_core_clk;
  logic       i_rstn;
  port_ctrl_t ctrl   [PORTS];
  data_t      rdata  [PORTS];
  addr_t      addr   [PORTS];
  lane_t      we     [PORTS];
  logic       rvalid [PORTS];
  logic       coll;
  data_t      dq     [PORTS];
  lane_t      oe_n   [PORTS];
  int         err_total;
  int         checks;
  int         cycles;

  dual_port_burst_address_counter dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_port_ctrl(ctrl),
    .i_array_rdata(rdata), .o_addr(addr), .o_array_we(we), .o_reload_valid(rvalid),
    .o_collision(coll), .o_dq_out(dq), .o_dq_oe_n(oe_n));
  burst_array_model array (.i_core_clk(i_core_clk), .i_addr(addr), .o_rdata(rdata));

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial
  begin
    i_core_clk = 1'h0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  task automatic conclude;
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial cycles = 0;
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles >= 2000)
    begin
      err_total++;
      conclude();
    end
  end

  // ****************************************
  // Compare and drive tasks
  // ****************************************
  task automatic fail(input string what);
    err_total++;
    $display("[FAIL] %0t %s", $time, what);
  endtask
  task automatic cmp_addr(input addr_t got, input addr_t exp);
    checks++;
    if (got !== exp) fail($sformatf("addr %h exp %h", got, exp));
  endtask
  task automatic cmp_lane(input lane_t got, input lane_t exp);
    checks++;
    if (got !== exp) fail($sformatf("lanes %h exp %h", got, exp));
  endtask
  task automatic cmp_data(input data_t got, input data_t exp);
    checks++;
    if (got !== exp) fail($sformatf("data %h exp %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail($sformatf("flag %b exp %b", got, exp));
  endtask
  // Port deselected, no counter action
  task automatic idle(input int p);
    ctrl[p] = '{ext_addr: ADDR_RESET, address_strobe_n: 1'h1, count_advance_n: 1'h1, reload_n: 1'h1,
                write_n: 1'h1, chip_select_low_n: 1'h1, chip_select_high: 1'h0,
                byte_lane_enable_n: 4'hF, output_enable_n: 1'h0, output_latency_select: 1'h0};
  endtask
  task automatic cnt(input int p, input logic s_n, input logic a_n, input logic r_n, input addr_t a);
    ctrl[p].address_strobe_n = s_n;
    ctrl[p].count_advance_n  = a_n;
    ctrl[p].reload_n         = r_n;
    ctrl[p].ext_addr         = a;
  endtask
  task automatic acc(input int p, input logic w_n, input lane_t be_n);
    ctrl[p].chip_select_low_n  = 1'h0;
    ctrl[p].chip_select_high   = 1'h1;
    ctrl[p].write_n            = w_n;
    ctrl[p].byte_lane_enable_n = be_n;
  endtask
  task automatic tick;
    @(posedge i_core_clk);
    #2;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    err_total = 0;
    checks = 0;
    idle(0);
    idle(1);
    i_rstn = 1'h0;
    repeat (10) @(posedge i_core_clk);
    #2;
    i_rstn = 1'h1;
    cmp_addr(addr[0], ADDR_RESET);
    cmp_bit(rvalid[0], 1'h0);
    // Loads while deselected; banks kept apart
    cnt(0, 1'h0, 1'h1, 1'h1, 18'h00FFF);
    cnt(1, 1'h0, 1'h0, 1'h1, 18'h3FFFF);
    tick;
    cmp_addr(addr[0], 18'h00FFF);
    cmp_addr(addr[1], 18'h3FFFF);
    cmp_bit(rvalid[0], 1'h1);
    cmp_bit(rvalid[1], 1'h1);
    cnt(0, 1'h1, 1'h0, 1'h1, 18'h2AAAA);
    cnt(1, 1'h1, 1'h0, 1'h1, 18'h2AAAA);
    tick;
    cmp_addr(addr[0], 18'h01000);
    cmp_addr(addr[1], 18'h00000);
    cnt(0, 1'h1, 1'h1, 1'h1, 18'h15555);
    cnt(1, 1'h1, 1'h1, 1'h1, 18'h15555);
    tick;
    cmp_addr(addr[0], 18'h01000);
    cmp_addr(addr[1], 18'h00000);
    // Reload beats a strobe and leaves the stored address alone
    cnt(0, 1'h0, 1'h0, 1'h0, 18'h0AAAA);
    cnt(1, 1'h1, 1'h1, 1'h0, 18'h0AAAA);
    tick;
    cmp_addr(addr[0], 18'h00FFF);
    cmp_addr(addr[1], 18'h3FFFF);
    cnt(0, 1'h1, 1'h0, 1'h1, 18'h0AAAA);
    cnt(1, 1'h1, 1'h1, 1'h1, 18'h0AAAA);
    tick;
    cnt(0, 1'h1, 1'h1, 1'h0, 18'h0AAAA);
    tick;
    cmp_addr(addr[0], 18'h00FFF);
    // Write lane decode
    cnt(0, 1'h1, 1'h1, 1'h1, 18'h0AAAA);
    acc(0, 1'h0, 4'hE);
    acc(1, 1'h0, 4'h3);
    tick;
    cmp_lane(we[0], 4'h1);
    cmp_lane(we[1], 4'hC);
    acc(0, 1'h0, 4'h0);
    ctrl[1].chip_select_high = 1'h0;
    tick;
    cmp_lane(we[0], 4'hF);
    cmp_lane(we[1], 4'h0);
    // Flow-through read, one request
    idle(1);
    acc(0, 1'h1, 4'h6);
    tick;
    cmp_data(dq[0], {18'h00FFF, 18'h00FFF});
    cmp_lane(oe_n[0], 4'h6);
    idle(0);
    cnt(0, 1'h1, 1'h0, 1'h1, 18'h0AAAA);
    tick;
    cmp_lane(oe_n[0], 4'hF);
    cmp_addr(addr[0], 18'h01000);
    // Pipelined read; address stepped so stale and fresh words differ
    cnt(0, 1'h1, 1'h1, 1'h1, 18'h0AAAA);
    ctrl[0].output_latency_select = 1'h1;
    acc(0, 1'h1, 4'h0);
    tick;
    cmp_lane(oe_n[0], 4'hF);
    ctrl[0].chip_select_low_n = 1'h1;
    tick;
    cmp_lane(oe_n[0], 4'h0);
    cmp_data(dq[0], {18'h00FFF, 18'h00FFF});
    // Output enable floats the pins between edges
    ctrl[0].output_enable_n = 1'h1;
    #1;
    cmp_lane(oe_n[0], 4'hF);
    tick;
    // Both counters in bank 1: write dropped, flow-through read blanked
    idle(0);
    cnt(1, 1'h0, 1'h1, 1'h1, 18'h01123);
    tick;
    cmp_bit(coll, 1'h0);
    cnt(1, 1'h1, 1'h1, 1'h1, 18'h01123);
    acc(0, 1'h0, 4'h0);
    acc(1, 1'h1, 4'h0);
    tick;
    cmp_bit(coll, 1'h1);
    cmp_lane(we[0], 4'h0);
    cmp_data(dq[1], 36'h000000000);
    cmp_lane(oe_n[1], 4'h0);
    conclude();
  end
endmodule // dual_port_burst_address_counter_tb
